// File: logic/sysint_pkg.sv
// System integration unit: shared constants, types and register map.
// Assumes one 10 MHz clock that also serves as the oscillator clock.
package sysint_pkg;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [15:0] SYSINT_IDX_BREAK_STATUS = 16'hFE00;
  localparam logic [15:0] SYSINT_IDX_RESET_CAUSE = 16'hFE01;
  localparam logic [15:0] SYSINT_IDX_BREAK_FLAG_CTRL = 16'hFF03;
  localparam int SYSINT_ADDR_W = 18;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int SYSINT_BIT_EXITED_WAIT = 1;
  localparam int SYSINT_BIT_CLEAR_ENABLE = 7;
  localparam int SYSINT_BIT_POWER_ON = 7;
  localparam int SYSINT_BIT_PIN = 6;
  localparam int SYSINT_BIT_WATCHDOG = 5;
  localparam int SYSINT_BIT_ILL_OPCODE = 4;
  localparam int SYSINT_BIT_ILL_ADDRESS = 3;
  localparam int SYSINT_BIT_MONITOR = 2;
  localparam int SYSINT_BIT_LOW_VOLTAGE = 1;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] SYSINT_RST_BREAK_STATUS = 8'h00;
  localparam logic [7:0] SYSINT_RST_RESET_CAUSE = 8'h80;
  localparam logic [7:0] SYSINT_RST_BREAK_FLAG_CTRL = 8'h00;

  // ---------------------------------------------------------------
  // Timing counts, in oscillator clock cycles
  // ---------------------------------------------------------------
  localparam int SYSINT_STOP_LONG_CYC = 4096;
  localparam int SYSINT_STOP_SHORT_CYC = 32;
  localparam int SYSINT_PIN_SAMPLE_CYC = 32;
  localparam int SYSINT_RST_DRIVE_CYC = 16;
  localparam int SYSINT_CNT_W = 13;

  // ---------------------------------------------------------------
  // AHB-Lite encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] SYSINT_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] SYSINT_HSIZE_WORD = 3'h2;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [5:0] {
    SYSINT_RUN        = 6'h01,
    SYSINT_WAIT       = 6'h02,
    SYSINT_STOP       = 6'h04,
    SYSINT_RECOVER    = 6'h08,
    SYSINT_RST_DRIVE  = 6'h10,
    SYSINT_RST_SAMPLE = 6'h20
  } sysint_state_e;

  // Internal reset sources, one-cycle pulses from on-chip logic
  typedef struct packed {
    logic watchdog;
    logic illegal_opcode;
    logic illegal_address;
    logic monitor_entry;
    logic low_voltage;
  } sysint_rst_src_s;

  // Clock gating outputs toward the clock generator
  typedef struct packed {
    logic cpu_clk_en;
    logic system_clock_out_en;
    logic oscillator_clock_en;
  } sysint_clk_s;

endpackage : sysint_pkg

// File: logic/sysint_unit.sv
// System integration unit: break flag protection, wait and stop
// sequencing, stop recovery timing and reset cause recording.
// Assumes CPU, break module and peripherals share clk; only the reset
// pin arrives from outside and is synchronised here.
//
// Overview of operation
// - A break request forces the CPU to the software-interrupt vector.
// - In break with clear enable low, set peripheral flags cannot clear.
// - With clear enable set, flags clear in break and stay cleared.
// - Two-step clears stay blocked in break; second step after break works.
// - Wait or stop instruction clears the global interrupt mask.
// - Wait mode stops CPU clocks, peripheral clocks keep running.
// - Enabled interrupt wakes wait; stacking starts the following cycle.
// - Reset or break ends wait; break in wait sets exited-wait flag.
// - Watchdog disable bit zero keeps watchdog enabled, also in wait.
// - Stop resets the counter and disables system and oscillator clocks.
// - Interrupt or reset ends stop; stacking waits for full recovery.
// - Recovery is 4096 oscillator cycles, or 32 with short recovery.
// - Counter held in reset during stop, then times the recovery.
// - Cause flags accumulate across resets until cleared.
// - Reading the reset cause register clears all its flags.
// - Power-on sets the power-on flag and clears all others.
// - Reset pin driven low in resets; sampled 32 cycles after release.
// - Separate flags for pin, watchdog, opcode, address, low voltage.
// - Monitor entry sets the monitor-entry flag.
// - Exited-wait flag is readable inside the break routine.
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
module sysint_unit
  import sysint_pkg::*;
#(
  parameter int STOP_LONG_CYC = SYSINT_STOP_LONG_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // CPU side
  input wire logic wait_exec,
  input wire logic stop_exec,
  input wire logic break_req,
  input wire logic break_done,
  input wire logic module_irq,
  output logic force_swi_vector,
  output logic clear_imask,
  output logic stack_start,
  output sysint_clk_s clk_gate,
  // Peripheral side
  output logic break_mode,
  output logic flag_clear_ok,
  output logic watchdog_enable,
  output logic internal_reset,
  // Configuration
  input wire logic watchdog_disable_bit,
  input wire logic short_stop_recovery,
  // Reset sources and reset pin
  input wire sysint_rst_src_s rst_src,
  input wire logic rst_pin_in,
  output logic rst_pin_out,
  output logic rst_pin_oe_n
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  localparam logic [SYSINT_CNT_W-1:0] LONG_END =
    SYSINT_CNT_W'(STOP_LONG_CYC - 1);
  localparam logic [SYSINT_CNT_W-1:0] SHORT_END =
    SYSINT_CNT_W'(SYSINT_STOP_SHORT_CYC - 1);
  localparam logic [SYSINT_CNT_W-1:0] SAMPLE_END =
    SYSINT_CNT_W'(SYSINT_PIN_SAMPLE_CYC - 1);
  localparam logic [SYSINT_CNT_W-1:0] DRIVE_END =
    SYSINT_CNT_W'(SYSINT_RST_DRIVE_CYC - 1);

  sysint_state_e state;
  sysint_state_e next_state;
  logic [SYSINT_CNT_W-1:0] counter;
  logic pin_s1;
  logic pin_s2;
  logic exited_wait;
  logic clear_enable;
  logic [7:0] reset_cause;
  logic wr_pend;
  logic [15:0] wr_idx;
  logic addr_ok;
  logic [15:0] a_idx;
  logic acc;
  logic rd_cause;
  logic any_src;
  logic ext_rst;
  logic rec_done;
  logic drive_done;
  logic sample_now;
  logic wake_wait;
  logic break_in_wait;
  logic stop_wake;

  // ---------------------------------------------------------------
  // Reset pin synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
    end else begin
      pin_s1 <= rst_pin_in;
      pin_s2 <= pin_s1;
    end
  end

  // ---------------------------------------------------------------
  // Sequencer conditions
  // ---------------------------------------------------------------
  assign any_src = |rst_src;
  // External pin pulled low outside the reset drive and sample states
  assign ext_rst = !pin_s2 && (state != SYSINT_RST_DRIVE) &&
                   (state != SYSINT_RST_SAMPLE);
  assign rec_done = (state == SYSINT_RECOVER) &&
    (counter == (short_stop_recovery ? SHORT_END : LONG_END));
  assign drive_done = (state == SYSINT_RST_DRIVE) && (counter == DRIVE_END);
  assign sample_now = (state == SYSINT_RST_SAMPLE) &&
                      (counter == SAMPLE_END);
  assign wake_wait = (state == SYSINT_WAIT) && module_irq;
  assign break_in_wait = (state == SYSINT_WAIT) && break_req;
  assign stop_wake = (state == SYSINT_STOP) && module_irq;

  // ---------------------------------------------------------------
  // Low-power and reset state machine
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      SYSINT_RUN: begin
        if (stop_exec) begin
          next_state = SYSINT_STOP;
        end else if (wait_exec) begin
          next_state = SYSINT_WAIT;
        end
      end
      SYSINT_WAIT: begin
        if (wake_wait || break_req) begin
          next_state = SYSINT_RUN;
        end
      end
      SYSINT_STOP: begin
        if (module_irq) begin
          next_state = SYSINT_RECOVER;
        end
      end
      SYSINT_RECOVER: begin
        if (rec_done) begin
          next_state = SYSINT_RUN;
        end
      end
      SYSINT_RST_DRIVE: begin
        if (drive_done) begin
          next_state = SYSINT_RST_SAMPLE;
        end
      end
      SYSINT_RST_SAMPLE: begin
        if (sample_now) begin
          next_state = SYSINT_RUN;
        end
      end
      default: begin
        next_state = SYSINT_RST_DRIVE;
      end
    endcase
    // Any reset source ends every mode, stop and wait included
    if (any_src || ext_rst) begin
      next_state = SYSINT_RST_DRIVE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= SYSINT_RST_DRIVE;
    end else begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // Shared counter: held at zero in stop, then times recovery
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      counter <= '0;
    end else if (next_state != state) begin
      counter <= '0;
    end else if (state == SYSINT_STOP || state == SYSINT_RUN ||
                 state == SYSINT_WAIT) begin
      counter <= '0;
    end else begin
      counter <= counter + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // CPU strobes
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      stack_start <= 1'b0;
      force_swi_vector <= 1'b0;
      clear_imask <= 1'b0;
    end else begin
      stack_start <= wake_wait || rec_done;
      force_swi_vector <= break_req && !break_mode &&
        (state == SYSINT_RUN || state == SYSINT_WAIT);
      clear_imask <= (state == SYSINT_RUN) &&
                     (wait_exec || stop_exec);
    end
  end

  // ---------------------------------------------------------------
  // Break mode and flag protection
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      break_mode <= 1'b0;
    end else if (internal_reset) begin
      break_mode <= 1'b0;
    end else if (break_req && (state == SYSINT_RUN ||
                               state == SYSINT_WAIT)) begin
      break_mode <= 1'b1;
    end else if (break_done) begin
      break_mode <= 1'b0;
    end
  end

  // Peripherals qualify every clearing step, first or second, with this
  assign flag_clear_ok = !break_mode || clear_enable;

  // ---------------------------------------------------------------
  // Clocks, watchdog, reset pin
  // ---------------------------------------------------------------
  always_comb begin
    clk_gate.cpu_clk_en = (state == SYSINT_RUN) ||
                          (state == SYSINT_RST_DRIVE) ||
                          (state == SYSINT_RST_SAMPLE);
    clk_gate.system_clock_out_en = (state != SYSINT_STOP) &&
                                   (state != SYSINT_RECOVER);
    clk_gate.oscillator_clock_en = (state != SYSINT_STOP);
  end

  assign watchdog_enable = !watchdog_disable_bit &&
    (state != SYSINT_STOP) && (state != SYSINT_RECOVER);
  assign internal_reset = (state == SYSINT_RST_DRIVE) ||
                          (state == SYSINT_RST_SAMPLE);
  assign rst_pin_out = 1'b0;
  assign rst_pin_oe_n = (state != SYSINT_RST_DRIVE);

  // ---------------------------------------------------------------
  // AHB-Lite slave: zero wait states, always OKAY
  // ---------------------------------------------------------------
  assign a_idx = haddr[SYSINT_ADDR_W-1:2];
  assign acc = hsel && hready && (htrans == SYSINT_HTRANS_NONSEQ);
  assign addr_ok = (a_idx == SYSINT_IDX_BREAK_STATUS) ||
                   (a_idx == SYSINT_IDX_RESET_CAUSE) ||
                   (a_idx == SYSINT_IDX_BREAK_FLAG_CTRL);
  assign rd_cause = acc && !hwrite && (a_idx == SYSINT_IDX_RESET_CAUSE);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wr_pend <= 1'b0;
      wr_idx <= 16'h0000;
    end else begin
      wr_pend <= acc && hwrite && addr_ok;
      wr_idx <= a_idx;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      hrdata <= 32'h00000000;
    end else if (acc && !hwrite) begin
      hrdata <= 32'h00000000;
      case (a_idx)
        SYSINT_IDX_BREAK_STATUS: begin
          hrdata[SYSINT_BIT_EXITED_WAIT] <= exited_wait;
        end
        SYSINT_IDX_RESET_CAUSE: begin
          hrdata[7:0] <= reset_cause;
        end
        SYSINT_IDX_BREAK_FLAG_CTRL: begin
          hrdata[SYSINT_BIT_CLEAR_ENABLE] <= clear_enable;
        end
        default: begin
          hrdata <= 32'h00000000;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Break status and break flag control registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      exited_wait <= SYSINT_RST_BREAK_STATUS[SYSINT_BIT_EXITED_WAIT];
    end else if (break_in_wait) begin
      exited_wait <= 1'b1;
    end else if (wr_pend && wr_idx == SYSINT_IDX_BREAK_STATUS &&
                 !hwdata[SYSINT_BIT_EXITED_WAIT]) begin
      exited_wait <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      clear_enable <= SYSINT_RST_BREAK_FLAG_CTRL[SYSINT_BIT_CLEAR_ENABLE];
    end else if (wr_pend && wr_idx == SYSINT_IDX_BREAK_FLAG_CTRL) begin
      clear_enable <= hwdata[SYSINT_BIT_CLEAR_ENABLE];
    end
  end

  // ---------------------------------------------------------------
  // Reset cause register: sets win over the read clear
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      reset_cause <= SYSINT_RST_RESET_CAUSE;
    end else begin
      reset_cause <= (rd_cause ? 8'h00 : reset_cause) |
        ({7'h00, rst_src.watchdog} << SYSINT_BIT_WATCHDOG) |
        ({7'h00, rst_src.illegal_opcode} << SYSINT_BIT_ILL_OPCODE) |
        ({7'h00, rst_src.illegal_address} << SYSINT_BIT_ILL_ADDRESS) |
        ({7'h00, rst_src.low_voltage} << SYSINT_BIT_LOW_VOLTAGE) |
        ({7'h00, rst_src.monitor_entry} << SYSINT_BIT_MONITOR) |
        ({7'h00, sample_now && !pin_s2} << SYSINT_BIT_PIN);
    end
  end

endmodule : sysint_unit
`default_nettype wire

// File: testbench/sysint_periph_model.sv
// Peripheral model: one status flag with a two-step clear, and the
// pulled-up reset line. Assumes the unit's clock, reset and permit.
`timescale 1ns/10ps
`default_nettype none
module sysint_periph_model
  import sysint_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic flag_clear_ok,
  input wire logic set_flag,
  input wire logic step1,
  input wire logic step2,
  input wire logic pull_low,
  input wire logic rst_pin_out,
  input wire logic rst_pin_oe_n,
  output logic flag,
  output logic rst_pin
);
  logic armed;
  // Pull-up wins unless the unit or the bench pulls low
  assign rst_pin = (!rst_pin_oe_n && !rst_pin_out) ? 1'h0 : !pull_low;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      flag <= 1'h0;
      armed <= 1'h0;
    end else begin
      if (step1 && flag && flag_clear_ok) begin
        armed <= 1'h1;
      end
      if (step2 && armed && flag_clear_ok) begin
        flag <= 1'h0;
        armed <= 1'h0;
      end
      if (set_flag) begin
        flag <= 1'h1;
      end
    end
  end
endmodule : sysint_periph_model
`default_nettype wire

// File: testbench/sysint_unit_chk.sv
// Port checker for the system integration unit.
// Assumes it is bound to sysint_unit and shares its clock and reset.
`timescale 1ns/10ps
`default_nettype none
module sysint_unit_chk
  import sysint_pkg::*;
#(
  parameter int STOP_LONG_CYC = SYSINT_STOP_LONG_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic wait_exec,
  input wire logic stop_exec,
  input wire logic break_req,
  input wire logic module_irq,
  input wire logic force_swi_vector,
  input wire logic clear_imask,
  input wire logic stack_start,
  input wire sysint_clk_s clk_gate,
  input wire logic break_mode,
  input wire logic flag_clear_ok,
  input wire logic watchdog_enable,
  input wire logic internal_reset,
  input wire logic watchdog_disable_bit,
  input wire logic short_stop_recovery,
  input wire sysint_rst_src_s rst_src,
  input wire logic rst_pin_out,
  input wire logic rst_pin_oe_n
);
  logic [13:0] rcnt;
  logic run;
  logic quiet;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  assign run = clk_gate.cpu_clk_en && !internal_reset;
  assign quiet = !break_req && rst_src == '0;
  // ---------------------------------------------------------------
  // Cycles spent in stop recovery
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn || clk_gate.system_clock_out_en
        || !clk_gate.oscillator_clock_en) begin
      rcnt <= '0;
    end else begin
      rcnt <= rcnt + 14'h1;
    end
  end
  a_break_entry: assert property (break_req && !break_mode && run
    && !wait_exec && !stop_exec && rst_src == '0 |-> ##[1:2] force_swi_vector)
    else $error("break not taken to the interrupt vector");
  a_clear_permit: assert property (!flag_clear_ok |-> break_mode)
    else $error("flag clear blocked outside break");
  a_imask_cause: assert property (clear_imask
    |-> $past(wait_exec) || $past(stop_exec))
    else $error("mask clear without wait or stop");
  a_wait_clocks: assert property (run && wait_exec && !stop_exec && quiet
    |=> !clk_gate.cpu_clk_en && clk_gate.system_clock_out_en
    && clk_gate.oscillator_clock_en) else $error("wait clock gating wrong");
  a_wait_wake: assert property (!clk_gate.cpu_clk_en && quiet && module_irq
    && clk_gate.system_clock_out_en && !internal_reset |-> ##[1:2] stack_start)
    else $error("wait not woken by interrupt");
  a_wdog_run: assert property (watchdog_enable == (!watchdog_disable_bit
    && clk_gate.system_clock_out_en)) else $error("watchdog enable wrong");
  a_stop_clocks: assert property (run && stop_exec && quiet
    |=> clk_gate == '0) else $error("stop clock gating wrong");
  a_stop_quiet: assert property (!clk_gate.system_clock_out_en |-> !stack_start)
    else $error("stacking before recovery ended");
  a_recover_len: assert property ($rose(clk_gate.system_clock_out_en)
    && !internal_reset && rcnt != 0 |-> rcnt == (short_stop_recovery ?
    SYSINT_STOP_SHORT_CYC : STOP_LONG_CYC) && stack_start)
    else $error("recovery length wrong");
  a_pin_drive: assert property (!rst_pin_oe_n |-> internal_reset && !rst_pin_out)
    else $error("reset pin driven outside reset");
endmodule : sysint_unit_chk
bind sysint_unit sysint_unit_chk #(.STOP_LONG_CYC(STOP_LONG_CYC)) u_chk (
  .clk(clk), .rstn(rstn), .wait_exec(wait_exec), .stop_exec(stop_exec),
  .break_req(break_req), .module_irq(module_irq),
  .force_swi_vector(force_swi_vector), .clear_imask(clear_imask),
  .stack_start(stack_start), .clk_gate(clk_gate), .break_mode(break_mode),
  .flag_clear_ok(flag_clear_ok), .watchdog_enable(watchdog_enable),
  .internal_reset(internal_reset), .rst_src(rst_src),
  .watchdog_disable_bit(watchdog_disable_bit), .rst_pin_out(rst_pin_out),
  .short_stop_recovery(short_stop_recovery), .rst_pin_oe_n(rst_pin_oe_n));
`default_nettype wire

// File: testbench/sysint_unit_tb_top.sv
// Self-checking bench: registers, reset causes, wait, stop and break.
// Assumes the checker is bound and the peripheral model is beside it.
`timescale 1ns/10ps
`default_nettype none
module sysint_unit_tb_top import sysint_pkg::*; ;
  typedef struct packed {
    logic [31:0] a;
    logic w;
    logic [7:0] d;
    logic [7:0] e;
  } sysint_row_s;
  localparam int STOP_SIM = 64;
  localparam logic [31:0] A_BS = {14'h0, SYSINT_IDX_BREAK_STATUS, 2'h0};
  localparam logic [31:0] A_RC = {14'h0, SYSINT_IDX_RESET_CAUSE, 2'h0};
  localparam logic [31:0] A_BF = {14'h0, SYSINT_IDX_BREAK_FLAG_CTRL, 2'h0};
  localparam logic [31:0] A_NX = A_BS + 32'h8;
  logic clk = 1'h0;
  logic rstn, hsel, hwrite, module_irq, wdb, ssr, pull_low, flag, pin;
  logic hreadyout, hresp, swi, imask, stack_start, break_mode, clr_ok;
  logic wdog_en, internal_reset, pin_out, pin_oe_n;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [6:0] strb;
  sysint_rst_src_s rst_src;
  sysint_clk_s clk_gate;
  int fails = 0;
  int comparisons = 0;
  int n;
  wire hready = hreadyout;
  sysint_row_s rows [10] = '{'{A_RC, 1'h0, 8'h00, 8'h80},
    '{A_RC, 1'h0, 8'h00, 8'h00}, '{A_BS, 1'h0, 8'h00, 8'h00},
    '{A_BF, 1'h0, 8'h00, 8'h00}, '{A_BF, 1'h1, 8'h80, 8'h00},
    '{A_BF, 1'h0, 8'h00, 8'h80}, '{A_NX, 1'h1, 8'hFF, 8'h00},
    '{A_NX, 1'h0, 8'h00, 8'h00}, '{A_BF, 1'h1, 8'h00, 8'h00},
    '{A_BF, 1'h0, 8'h00, 8'h00}};
  always #50 clk = ~clk;
  sysint_unit #(.STOP_LONG_CYC(STOP_SIM)) u_dut (
    .clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .wait_exec(strb[0]), .stop_exec(strb[1]), .break_req(strb[2]),
    .break_done(strb[3]), .module_irq(module_irq), .force_swi_vector(swi),
    .clear_imask(imask), .stack_start(stack_start), .clk_gate(clk_gate),
    .break_mode(break_mode), .flag_clear_ok(clr_ok),
    .watchdog_enable(wdog_en), .internal_reset(internal_reset),
    .watchdog_disable_bit(wdb), .short_stop_recovery(ssr),
    .rst_src(rst_src), .rst_pin_in(pin), .rst_pin_out(pin_out),
    .rst_pin_oe_n(pin_oe_n));
  sysint_periph_model u_periph (
    .clk(clk), .rstn(rstn), .flag_clear_ok(clr_ok), .set_flag(strb[4]),
    .step1(strb[5]), .step2(strb[6]), .pull_low(pull_low),
    .rst_pin_out(pin_out), .rst_pin_oe_n(pin_oe_n), .flag(flag),
    .rst_pin(pin));
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task conclude;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task edge_rdy;
    int i;
    i = 0;
    @(posedge clk);
    while (hready !== 1'h1) begin
      i++;
      if (i > 20) begin
        fails++;
        conclude();
      end
      @(posedge clk);
    end
  endtask : edge_rdy
  task bus(input logic [31:0] a, input logic w, input logic [7:0] d);
    @(posedge clk);
    hsel <= 1'h1;
    haddr <= a;
    hwrite <= w;
    htrans <= SYSINT_HTRANS_NONSEQ;
    edge_rdy();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    edge_rdy();
    rd = hrdata;
  endtask : bus
  task strobe(input int b);
    @(posedge clk);
    strb[b] <= 1'h1;
    @(posedge clk);
    strb[b] <= 1'h0;
  endtask : strobe
  task src(input logic [4:0] v);
    @(posedge clk);
    rst_src <= v;
    @(posedge clk);
    rst_src <= '0;
  endtask : src
  task wait_run;
    repeat (4) @(posedge clk);
    for (int i = 0; internal_reset !== 1'h0; i++) begin
      if (i > 300) begin
        fails++;
        conclude();
      end
      @(posedge clk);
    end
  endtask : wait_run
  task meas;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (stack_start !== 1'h1 && n < 300);
  endtask : meas
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    conclude();
  end
  initial begin
    rstn <= 1'h0;
    hsel <= 1'h0;
    haddr <= '0;
    htrans <= 2'h0;
    hwrite <= 1'h0;
    hsize <= SYSINT_HSIZE_WORD;
    hwdata <= '0;
    strb <= '0;
    module_irq <= 1'h0;
    wdb <= 1'h0;
    ssr <= 1'h0;
    pull_low <= 1'h0;
    rst_src <= '0;
    repeat (6) @(posedge clk);
    rstn <= 1'h1;
    wait_run();
    for (int k = 0; k < 10; k++) begin
      bus(rows[k].a, rows[k].w, rows[k].d);
      if (!rows[k].w) chk("register", rd, {24'h0, rows[k].e});
    end
    $display("test registers done");
    for (int i = 0; i < 5; i++) begin
      src(5'h01 << i);
      wait_run();
      bus(A_RC, 1'h0, 8'h00);
      chk("cause", rd, 32'h2 << i);
    end
    src(5'h10);
    wait_run();
    src(5'h01);
    wait_run();
    bus(A_RC, 1'h0, 8'h00);
    chk("accumulated", rd, 32'h22);
    @(posedge clk);
    pull_low <= 1'h1;
    repeat (60) @(posedge clk);
    pull_low <= 1'h0;
    wait_run();
    bus(A_RC, 1'h0, 8'h00);
    chk("pin cause", rd, 32'h40);
    src(5'h10);
    wait_run();
    @(posedge clk);
    rstn <= 1'h0;
    repeat (6) @(posedge clk);
    rstn <= 1'h1;
    wait_run();
    bus(A_RC, 1'h0, 8'h00);
    chk("power on", rd, 32'h80);
    $display("test reset causes done");
    strobe(0);
    repeat (2) @(posedge clk);
    chk("wait gates", clk_gate, 32'h3);
    chk("watchdog", wdog_en, 32'h1);
    module_irq <= 1'h1;
    meas();
    chk("wake", n, 32'h2);
    @(posedge clk);
    module_irq <= 1'h0;
    strobe(0);
    repeat (2) @(posedge clk);
    strobe(2);
    bus(A_BS, 1'h0, 8'h00);
    chk("exited wait", rd, 32'h2);
    chk("permit", clr_ok, 32'h0);
    bus(A_BS, 1'h1, 8'h00);
    bus(A_BS, 1'h0, 8'h00);
    chk("exited clear", rd, 32'h0);
    strobe(3);
    $display("test wait done");
    strobe(4);
    strobe(5);
    strobe(2);
    strobe(6);
    @(posedge clk);
    chk("protected", flag, 32'h1);
    strobe(3);
    strobe(6);
    @(posedge clk);
    chk("second step", flag, 32'h0);
    strobe(4);
    bus(A_BF, 1'h1, 8'h80);
    strobe(2);
    strobe(5);
    strobe(6);
    strobe(3);
    @(posedge clk);
    chk("clear in break", flag, 32'h0);
    bus(A_BF, 1'h1, 8'h00);
    $display("test break flags done");
    for (int s = 1; s >= 0; s--) begin
      @(posedge clk);
      ssr <= s[0];
      wdb <= 1'h1;
      strobe(1);
      repeat (3) @(posedge clk);
      chk("stop gates", clk_gate, 32'h0);
      module_irq <= 1'h1;
      meas();
      chk("recovery", n,
          s ? SYSINT_STOP_SHORT_CYC + 2 : STOP_SIM + 2);
      @(posedge clk);
      module_irq <= 1'h0;
      wdb <= 1'h0;
    end
    $display("test stop done");
    conclude();
  end
endmodule : sysint_unit_tb_top
`default_nettype wire
